// ---- common/rsb_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the rectifier status port
`ifndef RSB_CFG_SVH
`define RSB_CFG_SVH

// 7-bit bus address is the fixed upper nibble followed by address_select_2..0
`define RSB_ADDR_BASE 4'h7
`define RSB_ADDR_SEL_RESET 3'h7

// Status/control byte field positions
`define RSB_BIT_INPUT_GOOD 0
`define RSB_BIT_OUTPUT_GOOD 1
`define RSB_BIT_TEMP_NORMAL 3
`define RSB_BIT_ON_CMD 4
`define RSB_BIT_FAULT 5

// Commanded output state after bias power returns
`define RSB_ON_CMD_RESET 1'h1

// Over-temperature warning before shutdown
`define RSB_CLK_HZ 10000000
`define RSB_OT_WARN_S 10
`define RSB_OT_WARN_CYCLES (`RSB_OT_WARN_S * `RSB_CLK_HZ)

// Bit counter limit of one byte, acknowledge not counted
`define RSB_BITS_PER_BYTE 4'h8

`endif

// ---- common/rsb_pkg.sv ----
// Types shared by the rectifier status port
package rsb_pkg;

  // Supply condition inputs, all asynchronous to the clock
  typedef struct packed {
    logic input_in_range;
    logic output_present;
    logic over_temp;
    logic overvoltage_protection;
    logic overcurrent_protection;
    logic remote_on;
  } rsb_cond_s;

  // Status/control byte as seen by the serial host
  typedef struct packed {
    logic [1:0] unsupported_hi;
    logic fault_n;
    logic on_cmd;
    logic temp_normal;
    logic unsupported_2;
    logic output_good;
    logic input_good;
  } rsb_status_s;

  // Front-panel lamps
  typedef struct packed {
    logic input_good_lamp;
    logic output_good_lamp;
    logic fault_lamp;
  } rsb_lamps_s;

  typedef enum logic [2:0] {
    RSB_IDLE,
    RSB_ADDR,
    RSB_ACK_ADDR,
    RSB_WRITE,
    RSB_ACK_WRITE,
    RSB_READ,
    RSB_READ_ACK
  } rsb_state_e;

endpackage

// ---- design/rsb_status_port.sv ----
// Rectifier status/control byte expander with lamp and alarm-signal logic
// What this block does
// - Byte: input0, output1, temp3, command4, fault5
// - Bits 0,1,3,5 read-only, one when normal
// - Host biases rectifier when input power absent
// - Bit 4 reads and writes commanded state
// - Writing zero to bit 4 switches output off
// - Answer at 7Eh with all selects high
// - Plain byte transfers, no PEC byte
// - Input lamp green while input in range
// - Output lamp green while output present
// - Fault lamp red while any fault exists
// - Normal: lamps green, fault off, signals high
// - No input: input lamp off, fault red, input-good and fault low
// - Temperature alarm: fault and temp-normal low only
// - Address selects default high via pull-ups
// - Warn ten seconds, then shut down, restart
// - Fault on temperature, voltage, current, input, output
// - Output off on pin or command; command resets on
`timescale 1ns/100ps
`include "rsb_cfg.svh"

module rsb_status_port #(
  parameter int unsigned OT_WARN_CYCLES = `RSB_OT_WARN_CYCLES
) (
  input wire logic clock,
  input wire logic rst,
  input wire logic ce,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [2:0] address_select,
  input rsb_pkg::rsb_cond_s cond,
  output rsb_pkg::rsb_lamps_s lamps,
  output logic fault_n,
  output logic output_good,
  output logic input_good,
  output logic temp_normal,
  output logic main_output_on
);
  import rsb_pkg::*;

  // ************************************************************
  // Input synchronisers
  // ************************************************************
  logic [1:0] scl_meta_reg, sda_meta_reg;
  logic scl_reg, sda_reg, scl_prev_reg, sda_prev_reg;
  logic [2:0] sel_meta_reg, sel_reg;
  rsb_cond_s cond_meta_reg, cond_reg;

  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      scl_meta_reg <= 2'h3;
      sda_meta_reg <= 2'h3;
      sel_meta_reg <= `RSB_ADDR_SEL_RESET;
      sel_reg <= `RSB_ADDR_SEL_RESET;
      cond_meta_reg <= '0;
      cond_reg <= '0;
      scl_reg <= 1'h1;
      sda_reg <= 1'h1;
      scl_prev_reg <= 1'h1;
      sda_prev_reg <= 1'h1;
    end else if (ce) begin
      scl_meta_reg <= {scl_meta_reg[0], scl_in};
      sda_meta_reg <= {sda_meta_reg[0], sda_in};
      sel_meta_reg <= address_select;
      sel_reg <= sel_meta_reg;
      cond_meta_reg <= cond;
      cond_reg <= cond_meta_reg;
      scl_reg <= scl_meta_reg[1];
      sda_reg <= sda_meta_reg[1];
      scl_prev_reg <= scl_reg;
      sda_prev_reg <= sda_reg;
    end
  end

  // Edges are judged only past the two synchroniser stages
  wire scl_rise = scl_reg && !scl_prev_reg;
  wire scl_fall = !scl_reg && scl_prev_reg;
  wire bus_start = scl_reg && scl_prev_reg && sda_prev_reg && !sda_reg;
  wire bus_stop = scl_reg && scl_prev_reg && !sda_prev_reg && sda_reg;

  // ************************************************************
  // Supply condition and over-temperature timer
  // ************************************************************
  logic ot_shutdown_reg;
  logic [31:0] ot_count_reg;
  logic on_cmd_reg;

  wire ot_expired = ot_count_reg == OT_WARN_CYCLES - 32'h1;

  // Restart only once the temperature is back; warning spans the whole count
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      ot_count_reg <= 32'h0;
      ot_shutdown_reg <= 1'h0;
    end else if (ce) begin
      if (!cond_reg.over_temp) begin
        ot_count_reg <= 32'h0;
        ot_shutdown_reg <= 1'h0;
      end else if (ot_expired) begin
        ot_shutdown_reg <= 1'h1;
      end else if (!ot_shutdown_reg) begin
        ot_count_reg <= ot_count_reg + 32'h1;
      end
    end
  end

  wire any_fault = !cond_reg.input_in_range || cond_reg.over_temp
    || cond_reg.overvoltage_protection || cond_reg.overcurrent_protection
    || !cond_reg.output_present;
  wire out_allowed = cond_reg.input_in_range && cond_reg.remote_on && on_cmd_reg
    && !ot_shutdown_reg && !cond_reg.overvoltage_protection
    && !cond_reg.overcurrent_protection;

  rsb_status_s status_now;
  assign status_now.unsupported_hi = 2'h0;
  assign status_now.fault_n = !any_fault;
  assign status_now.on_cmd = on_cmd_reg;
  assign status_now.temp_normal = !cond_reg.over_temp;
  assign status_now.unsupported_2 = 1'h0;
  assign status_now.output_good = cond_reg.output_present;
  assign status_now.input_good = cond_reg.input_in_range;

  // Every indicator follows the synchronised condition, so all stay coherent
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      lamps <= '0;
      fault_n <= 1'h0;
      output_good <= 1'h0;
      input_good <= 1'h0;
      temp_normal <= 1'h1;
      main_output_on <= 1'h0;
    end else if (ce) begin
      lamps.input_good_lamp <= cond_reg.input_in_range;
      lamps.output_good_lamp <= cond_reg.output_present;
      lamps.fault_lamp <= any_fault;
      fault_n <= !any_fault;
      output_good <= cond_reg.output_present;
      input_good <= cond_reg.input_in_range;
      temp_normal <= !cond_reg.over_temp;
      main_output_on <= out_allowed;
    end
  end

  // ************************************************************
  // Serial byte port
  // ************************************************************
  rsb_state_e state_reg;
  logic [7:0] shift_reg, tx_reg;
  logic [3:0] cnt_reg;
  logic rw_reg;

  wire [6:0] own_addr = {`RSB_ADDR_BASE, sel_reg};
  wire addr_match = shift_reg[7:1] == own_addr;
  wire byte_done = cnt_reg == `RSB_BITS_PER_BYTE;
  wire [2:0] tx_idx = 3'h7 - cnt_reg[2:0];

  // A stop or a host NACK ends a transfer; no check byte is sent or awaited
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      state_reg <= RSB_IDLE;
      shift_reg <= 8'h00;
      tx_reg <= 8'h00;
      cnt_reg <= 4'h0;
      rw_reg <= 1'h0;
      sda_oe <= 1'h0;
      sda_out <= 1'h0;
      on_cmd_reg <= `RSB_ON_CMD_RESET;
    end else if (ce) begin
      if (bus_start) begin
        state_reg <= RSB_ADDR;
        cnt_reg <= 4'h0;
        sda_oe <= 1'h0;
      end else if (bus_stop) begin
        state_reg <= RSB_IDLE;
        sda_oe <= 1'h0;
      end else if (scl_rise) begin
        unique case (state_reg)
          RSB_ADDR, RSB_WRITE, RSB_READ: begin
            shift_reg <= {shift_reg[6:0], sda_reg};
            cnt_reg <= cnt_reg + 4'h1;
          end
          RSB_READ_ACK: begin
            cnt_reg <= 4'h0;
            if (sda_reg) begin
              state_reg <= RSB_IDLE;
            end else begin
              state_reg <= RSB_READ;
              tx_reg <= status_now;
            end
          end
          RSB_IDLE, RSB_ACK_ADDR, RSB_ACK_WRITE: begin
          end
        endcase
      end else if (scl_fall) begin
        unique case (state_reg)
          RSB_ADDR: begin
            if (byte_done && addr_match) begin
              state_reg <= RSB_ACK_ADDR;
              rw_reg <= shift_reg[0];
              sda_oe <= 1'h1;
            end else if (byte_done) begin
              state_reg <= RSB_IDLE;
            end
          end
          RSB_ACK_ADDR: begin
            cnt_reg <= 4'h0;
            if (rw_reg) begin
              state_reg <= RSB_READ;
              tx_reg <= status_now;
              sda_oe <= !status_now[7];
            end else begin
              state_reg <= RSB_WRITE;
              sda_oe <= 1'h0;
            end
          end
          RSB_WRITE: begin
            if (byte_done) begin
              on_cmd_reg <= shift_reg[`RSB_BIT_ON_CMD];
              state_reg <= RSB_ACK_WRITE;
              sda_oe <= 1'h1;
            end
          end
          RSB_ACK_WRITE: begin
            state_reg <= RSB_WRITE;
            cnt_reg <= 4'h0;
            sda_oe <= 1'h0;
          end
          RSB_READ: begin
            if (byte_done) begin
              state_reg <= RSB_READ_ACK;
              sda_oe <= 1'h0;
            end else begin
              sda_oe <= !tx_reg[tx_idx];
            end
          end
          RSB_IDLE, RSB_READ_ACK: begin
          end
        endcase
      end
    end
  end

  // ************************************************************
  // Checks
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_NO_INPUT: assert property (ce && !cond_reg.input_in_range |=>
    !lamps.input_good_lamp && lamps.fault_lamp && !input_good && !fault_n)
    else $error("no-input indication wrong");
  AST_NORMAL: assert property (ce && !any_fault |=>
    lamps.input_good_lamp && lamps.output_good_lamp && !lamps.fault_lamp
    && fault_n && output_good && input_good && temp_normal)
    else $error("normal indication wrong");
  AST_TEMP_ALARM: assert property (ce && cond_reg.over_temp && cond_reg.output_present
    && cond_reg.input_in_range |=>
    !temp_normal && !fault_n && lamps.fault_lamp && output_good && input_good)
    else $error("temperature alarm indication wrong");
  AST_OT_SHUTDOWN: assert property (ce && cond_reg.over_temp && ot_expired |=>
    ot_shutdown_reg ##1 (!ce || !main_output_on))
    else $error("over-temperature shutdown missing");
  AST_OT_RESTART: assert property (ce && !cond_reg.over_temp |=> !ot_shutdown_reg)
    else $error("shutdown not released");
  AST_CMD_OFF: assert property (ce && !on_cmd_reg |=> !main_output_on)
    else $error("output on despite off command");
  AST_PIN_OFF: assert property (ce && !cond_reg.remote_on |=> !main_output_on)
    else $error("output on despite remote off");
  AST_CMD_WRITE: assert property (ce && scl_fall && !bus_start && !bus_stop
    && state_reg == RSB_WRITE && byte_done |=>
    on_cmd_reg == $past(shift_reg[`RSB_BIT_ON_CMD]) && sda_oe)
    else $error("command bit not stored");
  AST_ADDR_NACK: assert property (ce && scl_fall && !bus_start && !bus_stop
    && state_reg == RSB_ADDR && byte_done && !addr_match |=>
    state_reg == RSB_IDLE && !sda_oe)
    else $error("foreign address acknowledged");
  AST_READ_LOAD: assert property (ce && scl_fall && !bus_start && !bus_stop
    && state_reg == RSB_ACK_ADDR && rw_reg |=>
    tx_reg[`RSB_BIT_FAULT] == $past(!any_fault)
    && tx_reg[`RSB_BIT_INPUT_GOOD] == $past(cond_reg.input_in_range))
    else $error("status byte wrong");

endmodule // rsb_status_port

// ---- bench/rsb_i2c_host.sv ----
// Serial bus host model that reads and commands the status byte
`timescale 1ns/100ps

module rsb_i2c_host (
  input wire logic clock,
  input wire logic sda_line,
  output logic scl,
  output logic sda_low
);
  // ****************
  // Bus phases
  // ****************
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  task automatic hold(input int n);
    repeat (n) @(posedge clock);
  endtask

  // Works from idle and as a repeated start; SCL stands high between frames
  task automatic start_cond();
    hold(1);
    sda_low <= 1'b0;
    hold(10);
    scl <= 1'b1;
    hold(10);
    sda_low <= 1'b1;
    hold(10);
    scl <= 1'b0;
    hold(8);
  endtask

  // Data changes 8 clocks after SCL falls, past the device's release delay
  task automatic send_bit(input logic b, output logic seen);
    sda_low <= !b;
    hold(10);
    scl <= 1'b1;
    hold(5);
    seen = sda_line;
    hold(5);
    scl <= 1'b0;
    hold(8);
  endtask

  // Plain byte plus acknowledge; no check byte is ever sent or expected
  task automatic xfer(input logic [7:0] tx, input logic ack_out, output logic [7:0] rx,
    output logic ack_in);
    logic s;
    for (int i = 7; i >= 0; i--) send_bit(tx[i], rx[i]);
    send_bit(!ack_out, s);
    ack_in = !s;
  endtask

  task automatic stop_cond();
    sda_low <= 1'b1;
    hold(10);
    scl <= 1'b1;
    hold(10);
    sda_low <= 1'b0;
    hold(10);
  endtask
endmodule // rsb_i2c_host

// ---- bench/tb.sv ----
// Self-checking testbench of the rectifier status port
`timescale 1ns/100ps

module tb;
  import rsb_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic [2:0] address_select = 3'h7;
  rsb_cond_s cond = 6'b110001;
  rsb_lamps_s lamps;
  logic sda_out, sda_oe, fault_n, output_good, input_good, temp_normal, main_output_on;
  logic scl, sda_low;
  int bad_count = 0;
  int compares = 0;
  // SDA has a pull-up: released by both parties it reads high
  wire sda_line = !((sda_oe && !sda_out) || sda_low);
  wire [7:0] ind = {lamps, fault_n, output_good, input_good, temp_normal, main_output_on};
  // Condition, wait in clocks, expected {lamps, fault_n, og, ig, tn, on}
  logic [5:0] case_cond [9] = '{6'h31, 6'h01, 6'h25, 6'h23, 6'h20, 6'h39, 6'h39, 6'h29, 6'h31};
  int case_wait [9] = '{5, 5, 5, 5, 5, 5, 25, 5, 5};
  logic [7:0] case_exp [9] = '{8'hDF, 8'h22, 8'hA6, 8'hA6, 8'hA6, 8'hED, 8'hEC, 8'hA4, 8'hDF};

  always #50 clock = ~clock;

  // Short warning count keeps the over-temperature run brief
  rsb_status_port #(.OT_WARN_CYCLES(20)) i_rsb_status_port (.clock(clock), .rst(rst),
    .ce(ce), .scl_in(scl), .sda_in(sda_line), .sda_out(sda_out), .sda_oe(sda_oe),
    .address_select(address_select), .cond(cond), .lamps(lamps), .fault_n(fault_n),
    .output_good(output_good), .input_good(input_good), .temp_normal(temp_normal),
    .main_output_on(main_output_on));

  rsb_i2c_host i_rsb_i2c_host (.clock(clock), .sda_line(sda_line), .scl(scl),
    .sda_low(sda_low));

  // ****************
  // Checking and bus tasks
  // ****************
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic end_sim();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic rd(input logic [7:0] addr, input logic exp_ack, input logic [7:0] exp);
    logic [7:0] d;
    logic a;
    i_rsb_i2c_host.start_cond();
    i_rsb_i2c_host.xfer(addr, 1'b0, d, a);
    check("address ack", {7'h0, exp_ack}, {7'h0, a});
    if (a === 1'b1) begin
      i_rsb_i2c_host.xfer(8'hFF, 1'b0, d, a);
      check("status byte", exp, d);
    end
    i_rsb_i2c_host.stop_cond();
  endtask

  task automatic wr(input logic [7:0] data);
    logic [7:0] d;
    logic a;
    i_rsb_i2c_host.start_cond();
    i_rsb_i2c_host.xfer(8'h7E, 1'b0, d, a);
    check("write address ack", 8'h01, {7'h0, a});
    i_rsb_i2c_host.xfer(data, 1'b0, d, a);
    check("data ack", 8'h01, {7'h0, a});
    i_rsb_i2c_host.stop_cond();
    @(negedge clock);
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    repeat (100000) @(posedge clock);
    bad_count++;
    end_sim();
  end

  initial begin
    repeat (3) @(negedge clock);
    check("reset indicators", 8'h02, ind);
    check("reset sda", 8'h00, {7'h0, sda_oe});
    @(posedge clock);
    rst <= 1'b0;
    for (int i = 0; i < 9; i++) begin
      @(posedge clock);
      cond <= case_cond[i];
      repeat (case_wait[i]) @(negedge clock);
      check("indicators", case_exp[i], ind);
    end
    // Clock enable low must freeze the synchronised condition
    @(posedge clock);
    ce <= 1'b0;
    cond <= 6'h01;
    repeat (5) @(negedge clock);
    check("frozen indicators", 8'hDF, ind);
    @(posedge clock);
    ce <= 1'b1;
    cond <= 6'h31;
    repeat (5) @(negedge clock);
    rd(8'h7F, 1'b1, 8'h3B);
    wr(8'h00);
    check("output after off", 8'h00, {7'h0, main_output_on});
    rd(8'h7F, 1'b1, 8'h2B);
    wr(8'h10);
    check("output after on", 8'h01, {7'h0, main_output_on});
    @(posedge clock);
    address_select <= 3'h6;
    rd(8'h7F, 1'b0, 8'h00);
    rd(8'h7D, 1'b1, 8'h3B);
    @(posedge clock);
    address_select <= 3'h7;
    cond <= 6'h01;
    rd(8'h7F, 1'b1, 8'h18);
    // Bias loss must bring the command back to on
    wr(8'h00);
    @(posedge clock);
    rst <= 1'b1;
    @(posedge clock);
    rst <= 1'b0;
    repeat (4) @(posedge clock);
    rd(8'h7F, 1'b1, 8'h18);
    end_sim();
  end
endmodule // tb
